// [common/asp_regs.vh]
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// Register addresses on the plain register port
`define ASP_ADDR_CTL   3'h0
`define ASP_ADDR_BUF   3'h1
`define ASP_ADDR_PWR   3'h2
`define ASP_ADDR_BAUD  3'h3
// Field positions of serial_control
`define ASP_CTL_B7     7
`define ASP_CTL_SM1    6
`define ASP_CTL_MPE    5
`define ASP_CTL_REN    4
`define ASP_CTL_TB8    3
`define ASP_CTL_RB8    2
`define ASP_CTL_TI     1
`define ASP_CTL_RI     0
// Field positions of power_control and of the timer select register
`define ASP_PWR_SPEED  7
`define ASP_PWR_EVS    6
`define ASP_BAUD_TXT   0
`define ASP_BAUD_RXT   1
// Reset values
`define ASP_CTL_RST    8'h00
`define ASP_BUF_RST    8'h00
`define ASP_PWR_RST    8'h00
`define ASP_BAUD_RST   8'h00
// Frame mode codes held in the two mode-select bits
`define ASP_MODE_SYNC  2'h0
`define ASP_MODE_TEN   2'h1
`define ASP_MODE_FIX   2'h2
`define ASP_MODE_VAR   2'h3
// Oversampling counter: last state, the three sample states, receive preload
`define ASP_OVS_LAST   4'hf
`define ASP_SMP_A      4'h6
`define ASP_SMP_B      4'h7
`define ASP_SMP_C      4'h8
`define ASP_RX_LOAD    9'h1ff
`define ASP_TX_MARK    8'h01
`endif

// [logic/asp_rx.v]
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.vh"
// Receive hunter, majority sampler and frame assembler
module asp_rx (
   input  wire       clk_in,     // System clock
   input  wire       rst_n_in,   // Async reset, active low
   input  wire       tick_in,    // 16x bit-rate enable
   input  wire       rxd_in,     // Synchronised serial line
   input  wire       enable_in,  // Receiver enable
   input  wire       eleven_in,  // 11-bit frame mode
   output reg        done_out,   // One-cycle frame-end pulse
   output reg  [7:0] byte_out,   // Received byte
   output reg        ninth_out,  // Ninth bit (stop bit in 10-bit mode)
   output reg        stop_out    // Received stop bit
);
   localparam ST_HUNT = 2'd0; // Looking for a falling edge
   localparam ST_RECV = 2'd1; // Sampling bits
   localparam ST_HOLD = 2'd2; // One bit time after an 11-bit frame
   reg [1:0] st_r;   // State
   reg [3:0] cnt_r;  // Divide-by-16 counter
   reg       prev_r; // Previous sample for edge detection
   reg       s0_r;   // First sample
   reg       s1_r;   // Second sample
   reg [9:0] shr_r;  // Input shift register
   wire      maj = (s0_r & s1_r) | (s0_r & rxd_in) | (s1_r & rxd_in);
   wire [9:0] shr_nxt = eleven_in ? {maj, shr_r[9:1]} : {1'b1, maj, shr_r[8:1]};
   wire       first_bit = (shr_r == {1'b1, `ASP_RX_LOAD});

   // Hunt, sample and shift on each 16x tick
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= ST_HUNT; cnt_r <= 4'h0; prev_r <= 1'b1; s0_r <= 1'b1; s1_r <= 1'b1;
         shr_r <= 10'h3ff; done_out <= 1'b0; byte_out <= 8'h00;
         ninth_out <= 1'b0; stop_out <= 1'b1;
      end else begin
         done_out <= 1'b0;
         if (tick_in) begin
            prev_r <= rxd_in;
            case (st_r)
               ST_HUNT: begin
                  if (enable_in && prev_r && !rxd_in) begin
                     cnt_r <= 4'h0;
                     shr_r <= {1'b1, `ASP_RX_LOAD};
                     st_r  <= ST_RECV;
                  end
               end
               ST_RECV: begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `ASP_SMP_A)
                     s0_r <= rxd_in;
                  if (cnt_r == `ASP_SMP_B)
                     s1_r <= rxd_in;
                  if (cnt_r == `ASP_SMP_C) begin
                     if (first_bit && maj) begin
                        st_r <= ST_HUNT;
                     end else begin
                        shr_r <= shr_nxt;
                        if (!shr_r[0]) begin
                           done_out  <= 1'b1;
                           byte_out  <= shr_nxt[7:0];
                           ninth_out <= shr_nxt[8];
                           stop_out  <= eleven_in ? shr_nxt[9] : shr_nxt[8];
                           st_r      <= eleven_in ? ST_HOLD : ST_HUNT;
                        end
                     end
                  end
               end
               ST_HOLD: begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `ASP_SMP_C)
                     st_r <= ST_HUNT;
               end
               default: st_r <= ST_HUNT;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// [logic/asp_top.v]
// Operation
// - 10-bit frame: start, 8 data LSB first, stop
// - 10-bit mode stores stop bit as ninth bit
// - 10-bit rate from timer 1 or 2 overflow
// - Buffer write requests; start after counter rollover
// - Start bit, then data, shift one bit later
// - Marker shifting; done at tenth rollover
// - Falling edge resets counter, loads all ones
// - Majority of samples at states 7-9
// - Nonzero start bit restarts the hunt
// - 10-bit accept needs done clear, stop check
// - 10-bit receiver hunts again after final shift
// - 11-bit frame carries programmable ninth bit
// - Fixed osc/16 or osc/32, else timer select
// - 11-bit transmit done at eleventh rollover
// - 11-bit accept gated by ninth bit
// - 11-bit stop bit leaves buffer untouched
// - Missing stop bit always sets framing error
// - Control bit 7 view chosen by power bit 6
// - Framing error cleared only by software
// - Multiproc enable gates receive-done on addresses
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.vh"
module asp_top (
   input  wire       clk_in,          // System clock, 200 MHz
   input  wire       rst_n_in,        // Async reset, active low
   input  wire [2:0] reg_addr_in,     // Register address
   input  wire [7:0] reg_wdata_in,    // Register write data
   input  wire       reg_wr_in,       // Write strobe
   input  wire       reg_rd_in,       // Read strobe
   output reg  [7:0] reg_rdata_out,   // Read data, one cycle later
   input  wire       timer1_ovf_in,   // Timer 1 overflow pulse
   input  wire       timer2_ovf_in,   // Timer 2 overflow pulse
   input  wire       rxd_in,          // Serial receive pin
   output wire       txd_out,         // Serial transmit pin
   output wire       tx_done_flag_out, // Transmit-done flag level
   output wire       rx_done_flag_out  // Receive-done flag level
);

   // ------------------------------------------------------------
   // Software-visible state
   // ------------------------------------------------------------
   reg       mode_select_high_r; // Mode bit 1, shares control bit 7
   reg       mode_select_low_r;  // Mode bit 0
   reg       multiproc_enable_r; // Address-frame filter enable
   reg       rx_enable_r;        // Receiver enable
   reg       tx_ninth_bit_r;     // Ninth bit to send
   reg       rx_ninth_bit_r;     // Ninth bit received
   reg       tx_done_flag_r;     // Sticky transmit done
   reg       rx_done_flag_r;     // Sticky receive done
   reg       framing_error_flag_r; // Sticky framing error
   reg [7:0] serial_buffer_r;    // Receive side of the buffer
   reg       speed_double_r;     // Rate doubler
   reg       error_view_select_r; // Control bit 7 view
   reg       tx_timer_select_r;  // Transmit uses timer 2
   reg       rx_timer_select_r;  // Receive uses timer 2

   // Next values of the flags
   reg       tx_done_flag_nxt;   // Next transmit done
   reg       rx_done_flag_nxt;   // Next receive done
   reg       framing_error_flag_nxt; // Next framing error

   // ------------------------------------------------------------
   // Pin synchroniser and rate enables
   // ------------------------------------------------------------
   reg       rxd_meta_r;         // First synchroniser stage
   reg       rxd_sync_r;         // Second synchroniser stage
   reg       osc_half_r;         // Oscillator divide-by-two
   reg       t1_half_r;          // Timer 1 overflow divide-by-two

   // ------------------------------------------------------------
   // Decoded access strobes
   // ------------------------------------------------------------
   wire wr_ctl = reg_wr_in && (reg_addr_in == `ASP_ADDR_CTL);  // Control write
   wire wr_buf = reg_wr_in && (reg_addr_in == `ASP_ADDR_BUF);  // Buffer write
   wire wr_pwr = reg_wr_in && (reg_addr_in == `ASP_ADDR_PWR);  // Power write
   wire wr_bsl = reg_wr_in && (reg_addr_in == `ASP_ADDR_BAUD); // Timer sel write

   // Frame mode and its derived qualifiers
   wire [1:0] mode     = {mode_select_high_r, mode_select_low_r};
   wire       eleven   = mode[1];                     // 11-bit frames
   wire       async_md = (mode != `ASP_MODE_SYNC);    // Asynchronous modes

   // ------------------------------------------------------------
   // Rate enables for the 16x oversampling counters
   // ------------------------------------------------------------
   // Fixed mode: every cycle when doubled, else every other cycle
   wire fix_tick = speed_double_r | osc_half_r;
   // Timer 1 overflow halved unless the doubler is set
   wire t1_tick  = timer1_ovf_in & (speed_double_r | t1_half_r);
   // Timer 2 overflow runs straight at 16x
   wire t2_tick  = timer2_ovf_in;
   // Per-direction timer choice for the variable-rate modes
   wire tx_var   = tx_timer_select_r ? t2_tick : t1_tick;
   wire rx_var   = rx_timer_select_r ? t2_tick : t1_tick;
   // Final tick per direction; the synchronous mode gets none here
   wire tx_tick  = !async_md ? 1'b0 :
                   (mode == `ASP_MODE_FIX) ? fix_tick : tx_var;
   wire rx_tick  = !async_md ? 1'b0 :
                   (mode == `ASP_MODE_FIX) ? fix_tick : rx_var;

   // ------------------------------------------------------------
   // Receiver outputs and the transmit end pulse
   // ------------------------------------------------------------
   wire       rx_done;   // Frame end pulse
   wire [7:0] rx_byte;   // Received byte
   wire       rx_ninth;  // Received ninth bit
   wire       rx_stop;   // Received stop bit
   wire       tx_done;   // Transmit end pulse

   // Accept test applied at the final shift
   wire rx_accept = rx_done && !rx_done_flag_r &&
                    (!multiproc_enable_r || rx_ninth);
   // Missing stop bit, in every asynchronous mode
   wire rx_frame_err = rx_done && !rx_stop;

   // ------------------------------------------------------------
   // Two-flop synchroniser on the receive pin
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rxd_meta_r <= 1'b1;
         rxd_sync_r <= 1'b1;
      end else begin
         rxd_meta_r <= rxd_in;
         rxd_sync_r <= rxd_meta_r;
      end
   end

   // ------------------------------------------------------------
   // Rate dividers
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_half_r <= 1'b0;
         t1_half_r  <= 1'b0;
      end else begin
         // Free-running halver for the fixed rate
         osc_half_r <= ~osc_half_r;
         // Halver advanced by each timer 1 overflow
         if (timer1_ovf_in)
            t1_half_r <= ~t1_half_r;
      end
   end

   // ------------------------------------------------------------
   // Flag next-state: hardware set beats a software clear
   // ------------------------------------------------------------
   always @* begin
      // Transmit done
      tx_done_flag_nxt = tx_done_flag_r;
      if (wr_ctl)
         tx_done_flag_nxt = reg_wdata_in[`ASP_CTL_TI];
      if (tx_done)
         tx_done_flag_nxt = 1'b1;
      // Receive done
      rx_done_flag_nxt = rx_done_flag_r;
      if (wr_ctl)
         rx_done_flag_nxt = reg_wdata_in[`ASP_CTL_RI];
      if (rx_accept)
         rx_done_flag_nxt = 1'b1;
      // Framing error, writable only through its own view
      framing_error_flag_nxt = framing_error_flag_r;
      if (wr_ctl && error_view_select_r)
         framing_error_flag_nxt = reg_wdata_in[`ASP_CTL_B7];
      if (rx_frame_err)
         framing_error_flag_nxt = 1'b1;
   end

   // ------------------------------------------------------------
   // Control register, flags and received data
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_select_high_r   <= 1'b0;
         mode_select_low_r    <= 1'b0;
         multiproc_enable_r   <= 1'b0;
         rx_enable_r          <= 1'b0;
         tx_ninth_bit_r       <= 1'b0;
         rx_ninth_bit_r       <= 1'b0;
         tx_done_flag_r       <= 1'b0;
         rx_done_flag_r       <= 1'b0;
         framing_error_flag_r <= 1'b0;
         serial_buffer_r      <= `ASP_BUF_RST;
      end else begin
         // Software writes of the plain control bits
         if (wr_ctl) begin
            // Bit 7 lands on the mode bit only in its mode view
            if (!error_view_select_r)
               mode_select_high_r <= reg_wdata_in[`ASP_CTL_B7];
            mode_select_low_r  <= reg_wdata_in[`ASP_CTL_SM1];
            multiproc_enable_r <= reg_wdata_in[`ASP_CTL_MPE];
            rx_enable_r        <= reg_wdata_in[`ASP_CTL_REN];
            tx_ninth_bit_r     <= reg_wdata_in[`ASP_CTL_TB8];
            rx_ninth_bit_r     <= reg_wdata_in[`ASP_CTL_RB8];
         end
         // Accepted frame overrides a software write of the ninth bit
         if (rx_accept) begin
            serial_buffer_r <= rx_byte;
            rx_ninth_bit_r  <= rx_ninth;
         end
         // Sticky flags
         tx_done_flag_r       <= tx_done_flag_nxt;
         rx_done_flag_r       <= rx_done_flag_nxt;
         framing_error_flag_r <= framing_error_flag_nxt;
      end
   end

   // ------------------------------------------------------------
   // Power and timer-select registers
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         speed_double_r      <= 1'b0;
         error_view_select_r <= 1'b0;
         tx_timer_select_r   <= 1'b0;
         rx_timer_select_r   <= 1'b0;
      end else begin
         // Rate doubler and bit 7 view select
         if (wr_pwr) begin
            speed_double_r      <= reg_wdata_in[`ASP_PWR_SPEED];
            error_view_select_r <= reg_wdata_in[`ASP_PWR_EVS];
         end
         // Timer choice for each direction
         if (wr_bsl) begin
            tx_timer_select_r <= reg_wdata_in[`ASP_BAUD_TXT];
            rx_timer_select_r <= reg_wdata_in[`ASP_BAUD_RXT];
         end
      end
   end

   // ------------------------------------------------------------
   // Read port: data stand in the cycle after the strobe only
   // ------------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            // Control with bit 7 in the selected view
            `ASP_ADDR_CTL: begin
               reg_rdata_out <= {(error_view_select_r ? framing_error_flag_r
                                  : mode_select_high_r),
                                 mode_select_low_r, multiproc_enable_r,
                                 rx_enable_r, tx_ninth_bit_r, rx_ninth_bit_r,
                                 tx_done_flag_r, rx_done_flag_r};
            end
            // Received byte
            `ASP_ADDR_BUF: begin
               reg_rdata_out <= serial_buffer_r;
            end
            // Power bits, rest zero
            `ASP_ADDR_PWR: begin
               reg_rdata_out <= {speed_double_r, error_view_select_r, 6'h00};
            end
            // Timer selects, rest zero
            `ASP_ADDR_BAUD: begin
               reg_rdata_out <= {6'h00, rx_timer_select_r, tx_timer_select_r};
            end
            // Unmapped addresses read zero
            default: begin
               reg_rdata_out <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Flag levels for the interrupt controller outside
   // ------------------------------------------------------------
   assign tx_done_flag_out = tx_done_flag_r;
   assign rx_done_flag_out = rx_done_flag_r;

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   asp_tx u_tx (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .tick_in   (tx_tick),
      .load_in   (wr_buf),
      .data_in   (reg_wdata_in),
      .ninth_in  (tx_ninth_bit_r),
      .eleven_in (eleven),
      .txd_out   (txd_out),
      .done_out  (tx_done),
      .busy_out  ()
   );

   // ------------------------------------------------------------
   // Receiver, hunting only in the asynchronous modes
   // ------------------------------------------------------------
   asp_rx u_rx (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .tick_in   (rx_tick),
      .rxd_in    (rxd_sync_r),
      .enable_in (rx_enable_r),
      .eleven_in (eleven),
      .done_out  (rx_done),
      .byte_out  (rx_byte),
      .ninth_out (rx_ninth),
      .stop_out  (rx_stop)
   );

endmodule
`default_nettype wire

// [logic/asp_tx.v]
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.vh"
// Transmit sequencer paced by its own divide-by-16 counter
module asp_tx (
   input  wire       clk_in,     // System clock
   input  wire       rst_n_in,   // Async reset, active low
   input  wire       tick_in,    // 16x bit-rate enable
   input  wire       load_in,    // Buffer write pulse
   input  wire [7:0] data_in,    // Byte to send
   input  wire       ninth_in,   // Ninth bit for 11-bit frames
   input  wire       eleven_in,  // 11-bit frame mode
   output reg        txd_out,    // Serial line out
   output reg        done_out,   // One-cycle end-of-frame pulse
   output wire       busy_out    // Request pending or sending
);
   reg [3:0] ovs_r;    // Divide-by-16 counter
   reg       pend_r;   // Transmission requested
   reg       send_r;   // Send phase
   reg       data_r;   // Data phase
   reg       first_r;  // Next shift is the first
   reg [8:0] shr_r;    // Transmit shift register
   wire      roll = tick_in && (ovs_r == `ASP_OVS_LAST);

   assign busy_out = pend_r | send_r;

   // Request, send, data and shift sequencing on counter rollovers
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ovs_r <= 4'h0; pend_r <= 1'b0; send_r <= 1'b0; data_r <= 1'b0;
         first_r <= 1'b0; shr_r <= 9'h000; txd_out <= 1'b1; done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (tick_in)
            ovs_r <= ovs_r + 4'h1;
         if (load_in && !send_r) begin
            pend_r <= 1'b1;
            shr_r  <= {(eleven_in ? ninth_in : 1'b1), data_in};
         end
         if (roll) begin
            if (pend_r && !send_r) begin
               send_r  <= 1'b1;
               pend_r  <= 1'b0;
               first_r <= 1'b1;
               txd_out <= 1'b0;
            end else if (send_r && !data_r) begin
               data_r  <= 1'b1;
               txd_out <= shr_r[0];
            end else if (send_r) begin
               first_r <= 1'b0;
               shr_r   <= {first_r & eleven_in, shr_r[8:1]};
               txd_out <= shr_r[1];
               if (!first_r && shr_r[8:1] == `ASP_TX_MARK) begin
                  send_r   <= 1'b0;
                  data_r   <= 1'b0;
                  done_out <= 1'b1;
                  txd_out  <= 1'b1;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/asp_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Checker on the top ports only
module asp_chk (
   input wire       clk_in, rst_n_in, reg_wr_in, reg_rd_in,
   input wire [2:0] reg_addr_in,
   input wire [7:0] reg_wdata_in, reg_rdata_out,
   input wire       timer1_ovf_in, timer2_ovf_in, rxd_in, txd_out,
   input wire       tx_done_flag_out, rx_done_flag_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire ctl_wr = reg_wr_in && reg_addr_in == 3'h0; // Software touches the flags
   a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (reg_rd_in && reg_addr_in[2] |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_flags_read: assert property (reg_rd_in && reg_addr_in == 3'h0 |=>
      reg_rdata_out[1:0] == {$past(tx_done_flag_out), $past(rx_done_flag_out)})
      else $error("flag read mismatch");
   a_rx_sticky: assert property (rx_done_flag_out && !ctl_wr |=> rx_done_flag_out)
      else $error("receive flag dropped by hardware");
   a_tx_sticky: assert property (tx_done_flag_out && !ctl_wr |=> tx_done_flag_out)
      else $error("transmit flag dropped by hardware");
   a_sw_set: assert property (ctl_wr && reg_wdata_in[0] |=> rx_done_flag_out)
      else $error("software set of receive flag lost");
   a_bit_hold: assert property ($changed(txd_out) |=> $stable(txd_out)[*8])
      else $error("transmit bit shorter than a bit time");
   a_stop_done: assert property ($rose(tx_done_flag_out) && !$past(reg_wr_in) |-> txd_out)
      else $error("transmit done without stop level");
endmodule
`default_nettype wire

// [tb/asp_peer.sv]
`timescale 1ns/1ps
`default_nettype none
// Remote station: sends LSB first, 16 cycles a bit, idles at mark
module asp_peer (
   input  wire        clk_in,  // Clock
   input  wire        go_in,   // Load a frame
   input  wire [10:0] bits_in, // Frame, start bit in bit 0
   input  wire [3:0]  len_in,  // Bits in frame
   output reg         line_out // Serial line
);
   reg [10:0] sh_r;
   reg [3:0]  n_r, c_r;
   initial begin
      line_out = 1'b1;
      n_r = 4'h0;
   end
   // Shift one bit every 16 cycles, mark between frames
   always @(posedge clk_in) begin
      if (go_in) begin
         sh_r <= bits_in;
         n_r  <= len_in;
         c_r  <= 4'h0;
      end else if (n_r != 4'h0) begin
         line_out <= sh_r[0];
         c_r <= c_r + 4'h1;
         if (c_r == 4'hf) begin
            sh_r <= sh_r >> 1;
            n_r  <= n_r - 4'h1;
         end
      end else line_out <= 1'b1;
   end
endmodule
`default_nettype wire

// [tb/tb_asp_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module tb_asp_top;
   reg clk_in = 1'b0, rst_n_in = 1'b0, wr_s = 1'b0, rd_s = 1'b0, go = 1'b0, gl_n = 1'b1;
   reg [2:0] addr = 3'h0;
   reg [7:0] wd = 8'h00, d;
   reg [10:0] bits = 11'h7ff, v;
   reg [3:0] len = 4'h0;
   wire [7:0] rdata;
   wire txd, txf, rxf, pline;
   integer failures = 0, check_count = 0;
   always #2.5 clk_in = ~clk_in;
   asp_top asp_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .timer1_ovf_in(1'b0), .timer2_ovf_in(1'b1), .rxd_in(pline & gl_n), .txd_out(txd),
      .tx_done_flag_out(txf), .rx_done_flag_out(rxf));
   asp_peer asp_peer_inst (.clk_in(clk_in), .go_in(go), .bits_in(bits), .len_in(len),
      .line_out(pline));
   task conclude;
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task wr(input [2:0] a, input [7:0] x);
      @(posedge clk_in); addr <= a; wd <= x; wr_s <= 1'b1;
      @(posedge clk_in); wr_s <= 1'b0;
   endtask
   task rd(input [2:0] a);
      @(posedge clk_in); addr <= a; rd_s <= 1'b1;
      @(posedge clk_in); rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   // Peer sends a frame, then the line settles
   task send(input [10:0] b, input [3:0] n);
      @(posedge clk_in); bits <= b; len <= n; go <= 1'b1;
      @(posedge clk_in); go <= 1'b0;
      repeat (n * 16 + 8) @(posedge clk_in);
   endtask
   // Mid-bit capture of n transmitted bits
   task txcap(input integer n);
      integer i;
      for (i = 0; i < 40 && txd; i++) @(posedge clk_in);
      repeat (8) @(posedge clk_in);
      for (i = 0; i < n; i++) begin v[i] = txd; repeat (16) @(posedge clk_in); end
   endtask
   task t_regs;
      integer i;
      for (i = 0; i < 4; i++) begin rd(i); `CK(d, 8'h00) end
      wr(3'h5, 8'hff); rd(3'h5); `CK(d, 8'h00)
      gl_n <= 1'b1;
   endtask
   task t_ten;
      wr(3'h3, 8'h03); wr(3'h0, 8'h50); wr(3'h1, 8'ha5); txcap(10);
      `CK(v[9:0], {1'b1, 8'ha5, 1'b0})
      `CK(txf, 1'b1)
      send({1'b1, 8'h3c, 1'b0}, 10); `CK(rxf, 1'b1)
      rd(3'h1); `CK(d, 8'h3c)
      rd(3'h0); `CK(d[2], 1'b1)
      send({1'b1, 8'hc3, 1'b0}, 10); rd(3'h1); `CK(d, 8'h3c)
      wr(3'h0, 8'h50); gl_n <= 1'b0; repeat (3) @(posedge clk_in); gl_n <= 1'b1;
      repeat (200) @(posedge clk_in); `CK(rxf, 1'b0)
      send({1'b1, 8'h77, 1'b0}, 10); rd(3'h1); `CK(d, 8'h77)
   endtask
   task t_frame;
      wr(3'h0, 8'h50); send({1'b0, 8'h11, 1'b0}, 10); wr(3'h2, 8'h40);
      rd(3'h0); `CK(d[7], 1'b1)
      wr(3'h0, 8'h50); rd(3'h0); `CK(d[7], 1'b0)
      wr(3'h2, 8'h00); rd(3'h0); `CK(d, 8'h50)
   endtask
   task t_eleven;
      wr(3'h2, 8'h80); wr(3'h0, 8'h98); wr(3'h1, 8'h5a); txcap(11);
      `CK(v, {2'h3, 8'h5a, 1'b0})
      wr(3'h0, 8'hb8); send({2'h2, 8'h12, 1'b0}, 11); `CK(rxf, 1'b0)
      send({2'h1, 8'h34, 1'b0}, 11); `CK(rxf, 1'b1)
      rd(3'h1); `CK(d, 8'h34)
      rd(3'h0); `CK(d[2], 1'b1)
   endtask
   initial begin
      #100000 failures++;
      conclude;
   end
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_regs; t_ten; t_frame; t_eleven;
      conclude;
   end
endmodule
bind asp_top asp_chk asp_chk_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .timer1_ovf_in(timer1_ovf_in),
   .timer2_ovf_in(timer2_ovf_in), .rxd_in(rxd_in), .txd_out(txd_out),
   .tx_done_flag_out(tx_done_flag_out), .rx_done_flag_out(rx_done_flag_out));
`default_nettype wire
